// file: pkg/cefm_regs.svh
`ifndef CEFM_REGS_SVH
`define CEFM_REGS_SVH
`define CEFM_ADDR_W 8
`define CEFM_DATA_W 8
`define CEFM_CHARGE_FLAGS_ADDR 8'h03
`define CEFM_FAULT_FLAGS_ADDR 8'h04
`define CEFM_ADC_FLAGS_ADDR 8'h05
`define CEFM_TIMER_FLAGS_ADDR 8'h06
`define CEFM_MASK_ADDR 8'h07
`define CEFM_FLAGS_RESET 8'h00
`define CEFM_MASK_RESET 8'h00
`define CEFM_CHARGE_USED 8'h7F
`define CEFM_FAULT_USED 8'hBF
`define CEFM_ADC_USED 8'hF1
`define CEFM_TIMER_USED 8'h77
`define CEFM_MASK_USED 8'h7F
`define CEFM_UVLO_BIT 4
`define CEFM_TAPER_BIT 6
`define CEFM_DONE_BIT 5
`define CEFM_ILIM_BIT 4
`define CEFM_ODPM_BIT 3
`define CEFM_IDPM_BIT 2
`define CEFM_TREG_BIT 1
`define CEFM_PGOOD_BIT 0
`define CEFM_OVERV_BIT 7
`define CEFM_BATOC_BIT 5
`define CEFM_COLD_BIT 3
`define CEFM_COOL_BIT 2
`define CEFM_WARM_BIT 1
`define CEFM_HOT_BIT 0
`define CEFM_ADCRDY_BIT 7
`define CEFM_CMP1_BIT 6
`define CEFM_CMP2_BIT 5
`define CEFM_CMP3_BIT 4
`define CEFM_TSOPEN_BIT 0
`define CEFM_WDOG_BIT 6
`define CEFM_CHGTMR_BIT 5
`define CEFM_AUXOC_BIT 4
`define CEFM_WAKE1_BIT 2
`define CEFM_WAKE2_BIT 1
`define CEFM_RSTWARN_BIT 0
`define CEFM_RD_ZERO 8'h00
`endif

// file: pkg/cefm_pkg.sv
package cefm_pkg;
	typedef logic [7:0] cefm_byte_t;
	typedef enum logic [2:0] {
		CEFM_IDLE = 3'b001,
		CEFM_READ = 3'b010,
		CEFM_CLEAR = 3'b100
	} cefm_rd_state_t;
endpackage : cefm_pkg

// file: core/cefm_sync.sv
`timescale 1ns/100ps
module cefm_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Async level in, filtered level and rise out
	input wire logic asyncIn,
	output logic levelOut,
	output logic riseOut
);
	import cefm_pkg::*;
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic lvl_ff;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
		end else begin
			s1_ff <= asyncIn;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Level changes only once the last two stages agree
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lvl_ff <= 1'b0;
		end else if (s2_ff == s3_ff) begin
			lvl_ff <= s3_ff;
		end
	end

	assign levelOut = lvl_ff;
	assign riseOut = (s2_ff == s3_ff) && s3_ff && !lvl_ff;
endmodule : cefm_sync

// file: core/cefm_flag_reg.sv
`timescale 1ns/100ps
`include "cefm_regs.svh"
module cefm_flag_reg (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Event pulses, one per bit
	input wire cefm_pkg::cefm_byte_t setIn,
	// Clear all flags after a read
	input wire logic clearIn,
	// Implemented bits
	input wire cefm_pkg::cefm_byte_t usedMask,
	// Current flags and newly set bits
	output cefm_pkg::cefm_byte_t flagsOut,
	output logic newOut
);
	import cefm_pkg::*;
	cefm_byte_t flags_ff;
	cefm_byte_t nxt_flags;

	// Set wins over the read clear so an event arriving in the clear cycle is not lost
	always_comb begin
		nxt_flags = clearIn ? `CEFM_FLAGS_RESET : flags_ff;
		nxt_flags = (nxt_flags | setIn) & usedMask;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flags_ff <= `CEFM_FLAGS_RESET;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	assign flagsOut = flags_ff;
	assign newOut = |(setIn & usedMask);
endmodule : cefm_flag_reg

// file: core/cefm_event_flags.sv
`timescale 1ns/100ps
`include "cefm_regs.svh"
module cefm_event_flags (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Register port from the serial slave
	input wire logic [`CEFM_ADDR_W-1:0] regAddr,
	input wire logic regRd,
	input wire logic regWr,
	input wire cefm_pkg::cefm_byte_t regWdata,
	output cefm_pkg::cefm_byte_t regRdata,
	// Charge-state conditions, levels from the analog side
	input wire logic taperEntryEvent,
	input wire logic chargeDoneEvent,
	input wire logic inputLimitEvent,
	input wire logic outputDpmEvent,
	input wire logic inputDpmEvent,
	input wire logic thermalRegEvent,
	input wire logic inputPowerGood,
	// Supply and thermistor faults
	input wire logic inputOvervoltageEvent,
	input wire logic batteryOvercurrentEvent,
	input wire logic batteryUndervoltageEvent,
	input wire logic thermistorColdEntry,
	input wire logic thermistorCoolEntry,
	input wire logic thermistorWarmEntry,
	input wire logic thermistorHotEntry,
	// ADC events
	input wire logic adcReadyEvent,
	input wire logic comparatorOneAlarm,
	input wire logic comparatorTwoAlarm,
	input wire logic comparatorThreeAlarm,
	input wire logic thermistorOpenEvent,
	// Timer faults
	input wire logic watchdogExpiryEvent,
	input wire logic chargeTimerExpiryEvent,
	input wire logic auxRegulatorOvercurrentEvent,
	input wire logic buttonWakeFirstExpiry,
	input wire logic buttonWakeSecondExpiry,
	input wire logic buttonResetWarningExpiry,
	// Interrupt request, active high level
	output logic irqReq
);
	import cefm_pkg::*;

	localparam int NEV = 24;
	logic [NEV-1:0] rawEv;
	logic [NEV-1:0] lvl;
	logic [NEV-1:0] rise;
	logic pgPrev_ff;
	logic pgSeen_ff;

	// Event slots in the synchroniser bank
	localparam int EV_TAPER = 23;
	localparam int EV_DONE = 22;
	localparam int EV_ILIM = 21;
	localparam int EV_ODPM = 20;
	localparam int EV_IDPM = 19;
	localparam int EV_TREG = 18;
	localparam int EV_PGOOD = 17;
	localparam int EV_OVERV = 16;
	localparam int EV_BATOC = 15;
	localparam int EV_BATUV = 14;
	localparam int EV_COLD = 13;
	localparam int EV_COOL = 12;
	localparam int EV_WARM = 11;
	localparam int EV_HOT = 10;
	localparam int EV_ADCRDY = 9;
	localparam int EV_CMP1 = 8;
	localparam int EV_CMP2 = 7;
	localparam int EV_CMP3 = 6;
	localparam int EV_TSOPEN = 5;
	localparam int EV_WDOG = 4;
	localparam int EV_CHGTMR = 3;
	localparam int EV_AUXOC = 2;
	localparam int EV_WAKE1 = 1;
	localparam int EV_WAKE2 = 0;

	assign rawEv[EV_TAPER] = taperEntryEvent;
	assign rawEv[EV_DONE] = chargeDoneEvent;
	assign rawEv[EV_ILIM] = inputLimitEvent;
	assign rawEv[EV_ODPM] = outputDpmEvent;
	assign rawEv[EV_IDPM] = inputDpmEvent;
	assign rawEv[EV_TREG] = thermalRegEvent;
	assign rawEv[EV_PGOOD] = inputPowerGood;
	assign rawEv[EV_OVERV] = inputOvervoltageEvent;
	assign rawEv[EV_BATOC] = batteryOvercurrentEvent;
	assign rawEv[EV_BATUV] = batteryUndervoltageEvent;
	assign rawEv[EV_COLD] = thermistorColdEntry;
	assign rawEv[EV_COOL] = thermistorCoolEntry;
	assign rawEv[EV_WARM] = thermistorWarmEntry;
	assign rawEv[EV_HOT] = thermistorHotEntry;
	assign rawEv[EV_ADCRDY] = adcReadyEvent;
	assign rawEv[EV_CMP1] = comparatorOneAlarm;
	assign rawEv[EV_CMP2] = comparatorTwoAlarm;
	assign rawEv[EV_CMP3] = comparatorThreeAlarm;
	assign rawEv[EV_TSOPEN] = thermistorOpenEvent;
	assign rawEv[EV_WDOG] = watchdogExpiryEvent;
	assign rawEv[EV_CHGTMR] = chargeTimerExpiryEvent;
	assign rawEv[EV_AUXOC] = auxRegulatorOvercurrentEvent;
	assign rawEv[EV_WAKE1] = buttonWakeFirstExpiry;
	assign rawEv[EV_WAKE2] = buttonWakeSecondExpiry;

	// Events come from analog blocks outside this clock
	genvar gi;
	generate
		for (gi = 0; gi < NEV; gi++) begin : gSync
			cefm_sync uSync (
				.clk(clk),
				.sys_rst(sys_rst),
				.asyncIn(rawEv[gi]),
				.levelOut(lvl[gi]),
				.riseOut(rise[gi])
			);
		end
	endgenerate

	logic rstWarnLvl;
	logic rstWarnRise;
	cefm_sync uSyncWarn (
		.clk(clk),
		.sys_rst(sys_rst),
		.asyncIn(buttonResetWarningExpiry),
		.levelOut(rstWarnLvl),
		.riseOut(rstWarnRise)
	);

	// Power-good flags any change, so track its previous level
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pgPrev_ff <= 1'b0;
			pgSeen_ff <= 1'b0;
		end else begin
			pgPrev_ff <= lvl[EV_PGOOD];
			pgSeen_ff <= 1'b1;
		end
	end

	// Read handshake: capture, then clear the register read
	cefm_rd_state_t rdState_ff;
	logic [`CEFM_ADDR_W-1:0] rdAddr_ff;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdState_ff <= CEFM_IDLE;
		end else begin
			unique case (rdState_ff)
				CEFM_IDLE: rdState_ff <= regRd ? CEFM_READ : CEFM_IDLE;
				CEFM_READ: rdState_ff <= CEFM_CLEAR;
				CEFM_CLEAR: rdState_ff <= CEFM_IDLE;
				default: rdState_ff <= CEFM_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdAddr_ff <= '0;
		end else if (regRd && rdState_ff == CEFM_IDLE) begin
			rdAddr_ff <= regAddr;
		end
	end

	logic clrCharge;
	logic clrFault;
	logic clrAdc;
	logic clrTimer;
	logic clrNow;
	assign clrNow = rdState_ff == CEFM_CLEAR;
	assign clrCharge = clrNow && rdAddr_ff == `CEFM_CHARGE_FLAGS_ADDR;
	assign clrFault = clrNow && rdAddr_ff == `CEFM_FAULT_FLAGS_ADDR;
	assign clrAdc = clrNow && rdAddr_ff == `CEFM_ADC_FLAGS_ADDR;
	assign clrTimer = clrNow && rdAddr_ff == `CEFM_TIMER_FLAGS_ADDR;

	// Set vectors, edge-triggered so flags latch entry events
	cefm_byte_t setCharge;
	cefm_byte_t setFault;
	cefm_byte_t setAdc;
	cefm_byte_t setTimer;
	logic pgChange;
	assign pgChange = pgSeen_ff && (lvl[EV_PGOOD] != pgPrev_ff);

	always_comb begin
		setCharge = '0;
		setCharge[`CEFM_TAPER_BIT] = rise[EV_TAPER];
		setCharge[`CEFM_DONE_BIT] = rise[EV_DONE];
		setCharge[`CEFM_ILIM_BIT] = rise[EV_ILIM];
		setCharge[`CEFM_ODPM_BIT] = rise[EV_ODPM];
		setCharge[`CEFM_IDPM_BIT] = rise[EV_IDPM];
		setCharge[`CEFM_TREG_BIT] = rise[EV_TREG];
		setCharge[`CEFM_PGOOD_BIT] = pgChange;
	end

	always_comb begin
		setFault = '0;
		setFault[`CEFM_OVERV_BIT] = rise[EV_OVERV];
		setFault[`CEFM_BATOC_BIT] = rise[EV_BATOC];
		setFault[`CEFM_UVLO_BIT] = rise[EV_BATUV];
		setFault[`CEFM_COLD_BIT] = rise[EV_COLD];
		setFault[`CEFM_COOL_BIT] = rise[EV_COOL];
		setFault[`CEFM_WARM_BIT] = rise[EV_WARM];
		setFault[`CEFM_HOT_BIT] = rise[EV_HOT];
	end

	always_comb begin
		setAdc = '0;
		setAdc[`CEFM_ADCRDY_BIT] = rise[EV_ADCRDY];
		setAdc[`CEFM_CMP1_BIT] = rise[EV_CMP1];
		setAdc[`CEFM_CMP2_BIT] = rise[EV_CMP2];
		setAdc[`CEFM_CMP3_BIT] = rise[EV_CMP3];
		setAdc[`CEFM_TSOPEN_BIT] = rise[EV_TSOPEN];
	end

	always_comb begin
		setTimer = '0;
		setTimer[`CEFM_WDOG_BIT] = rise[EV_WDOG];
		setTimer[`CEFM_CHGTMR_BIT] = rise[EV_CHGTMR];
		setTimer[`CEFM_AUXOC_BIT] = rise[EV_AUXOC];
		setTimer[`CEFM_WAKE1_BIT] = rise[EV_WAKE1];
		setTimer[`CEFM_WAKE2_BIT] = rise[EV_WAKE2];
		setTimer[`CEFM_RSTWARN_BIT] = rstWarnRise;
	end

	cefm_byte_t chargeFlags;
	cefm_byte_t faultFlags;
	cefm_byte_t adcFlags;
	cefm_byte_t timerFlags;
	logic newCharge;
	logic newFault;
	logic newAdc;
	logic newTimer;

	// Flags hold until their register is read
	cefm_flag_reg uCharge (
		.clk(clk),
		.sys_rst(sys_rst),
		.setIn(setCharge),
		.clearIn(clrCharge),
		.usedMask(`CEFM_CHARGE_USED),
		.flagsOut(chargeFlags),
		.newOut(newCharge)
	);
	cefm_flag_reg uFault (
		.clk(clk),
		.sys_rst(sys_rst),
		.setIn(setFault),
		.clearIn(clrFault),
		.usedMask(`CEFM_FAULT_USED),
		.flagsOut(faultFlags),
		.newOut(newFault)
	);
	cefm_flag_reg uAdc (
		.clk(clk),
		.sys_rst(sys_rst),
		.setIn(setAdc),
		.clearIn(clrAdc),
		.usedMask(`CEFM_ADC_USED),
		.flagsOut(adcFlags),
		.newOut(newAdc)
	);
	cefm_flag_reg uTimer (
		.clk(clk),
		.sys_rst(sys_rst),
		.setIn(setTimer),
		.clearIn(clrTimer),
		.usedMask(`CEFM_TIMER_USED),
		.flagsOut(timerFlags),
		.newOut(newTimer)
	);

	// Charge-state mask register
	cefm_byte_t mask_ff;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mask_ff <= `CEFM_MASK_RESET;
		end else if (regWr && regAddr == `CEFM_MASK_ADDR) begin
			mask_ff <= regWdata & `CEFM_MASK_USED;
		end
	end

	// Interrupt request: held until the host reads any of the four flag registers
	logic irq_ff;
	logic nxt_irq;
	// Mask or unmapped reads must not drop a pending request
	logic clrFlagReg;
	logic irqSet;
	assign clrFlagReg = clrCharge || clrFault || clrAdc || clrTimer;
	assign irqSet = |(setCharge & ~mask_ff) || newFault || newAdc || newTimer;

	always_comb begin
		nxt_irq = irq_ff;
		if (clrFlagReg) begin
			nxt_irq = 1'b0;
		end
		if (irqSet) begin
			nxt_irq = 1'b1;
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_irq;
		end
	end
	assign irqReq = irq_ff;

	// Read data, registered; undervoltage shown inverted
	cefm_byte_t faultView;
	assign faultView = faultFlags ^ (8'h01 << `CEFM_UVLO_BIT);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			regRdata <= `CEFM_RD_ZERO;
		end else if (regRd && rdState_ff == CEFM_IDLE) begin
			unique case (regAddr)
				`CEFM_CHARGE_FLAGS_ADDR: regRdata <= chargeFlags;
				`CEFM_FAULT_FLAGS_ADDR: regRdata <= faultView;
				`CEFM_ADC_FLAGS_ADDR: regRdata <= adcFlags;
				`CEFM_TIMER_FLAGS_ADDR: regRdata <= timerFlags;
				`CEFM_MASK_ADDR: regRdata <= mask_ff;
				default: regRdata <= `CEFM_RD_ZERO;
			endcase
		end
	end
endmodule : cefm_event_flags

// file: tb/cefm_asserts.sv
`timescale 1ns/100ps
module cefm_asserts (
	// Clock, reset and register port
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] regAddr,
	input wire logic regRd,
	input wire logic regWr,
	input wire cefm_pkg::cefm_byte_t regWdata,
	input wire cefm_pkg::cefm_byte_t regRdata,
	// Watched event and request
	input wire logic inputOvervoltageEvent,
	input wire logic irqReq
);
	import cefm_pkg::*;
	cefm_byte_t maskShadow_ff;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Shadow of the mask register, reserved bit kept at zero
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) maskShadow_ff <= 8'h00;
		else if (regWr && regAddr == 8'h07) maskShadow_ff <= regWdata & 8'h7F;
	end
	sequence s_rd(logic [7:0] a); regRd && regAddr == a; endsequence
	property p_mask; s_rd(8'h07) |=> regRdata == maskShadow_ff; endproperty
	property p_chg; s_rd(8'h03) |=> !regRdata[7]; endproperty
	property p_flt; s_rd(8'h04) |=> !regRdata[6]; endproperty
	property p_adc; s_rd(8'h05) |=> (regRdata & 8'h0E) == 8'h00; endproperty
	property p_tmr; s_rd(8'h06) |=> (regRdata & 8'h88) == 8'h00; endproperty
	property p_hold; !regRd |=> $stable(regRdata); endproperty
	property p_ovp; $rose(inputOvervoltageEvent) |-> ##[2:5] irqReq; endproperty
	property p_fall;
		$fell(irqReq) |-> $past(regRd, 2) || $past(regRd, 3);
	endproperty
	a_mask: assert property (p_mask) else $error("mask readback");
	a_chg: assert property (p_chg) else $error("charge bit 7");
	a_flt: assert property (p_flt) else $error("fault bit 6");
	a_adc: assert property (p_adc) else $error("adc reserved");
	a_tmr: assert property (p_tmr) else $error("timer reserved");
	a_hold: assert property (p_hold) else $error("read data moved");
	a_ovp: assert property (p_ovp) else $error("no irq on overvoltage");
	a_fall: assert property (p_fall) else $error("irq fell unread");
endmodule : cefm_asserts

bind cefm_event_flags cefm_asserts u_asserts (
	.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regRd(regRd),
	.regWr(regWr), .regWdata(regWdata), .regRdata(regRdata),
	.inputOvervoltageEvent(inputOvervoltageEvent), .irqReq(irqReq)
);

// file: tb/cefm_host_model.sv
`timescale 1ns/100ps
module cefm_host_model (
	// Clock
	input wire logic clk,
	// Register port toward the flag block
	output logic [7:0] regAddr,
	output logic regRd,
	output logic regWr,
	output cefm_pkg::cefm_byte_t regWdata,
	input wire cefm_pkg::cefm_byte_t regRdata
);
	import cefm_pkg::*;
	initial begin
		regAddr = 8'h00;
		regRd = 1'b0;
		regWr = 1'b0;
		regWdata = 8'h00;
	end
	// One-cycle strobe, data a cycle later, spacing of at least 3 cycles
	task automatic rd(input logic [7:0] a, output cefm_byte_t d);
		@(posedge clk) #10;
		regAddr = a;
		regRd = 1'b1;
		@(posedge clk) #10;
		regRd = 1'b0;
		regAddr = ~a;
		@(posedge clk) #10;
		d = regRdata;
		@(posedge clk);
	endtask : rd
	task automatic wr(input logic [7:0] a, input cefm_byte_t d);
		@(posedge clk) #10;
		regAddr = a;
		regWdata = d;
		regWr = 1'b1;
		@(posedge clk) #10;
		regWr = 1'b0;
		regWdata = ~d;
		regAddr = ~a;
	endtask : wr
endmodule : cefm_host_model

// file: tb/charger_event_flags_masks_tb_top.sv
`timescale 1ns/100ps
module charger_event_flags_masks_tb_top;
	import cefm_pkg::*;
	logic clk;
	logic sys_rst;
	logic [24:0] evt;
	logic [7:0] regAddr;
	logic regRd;
	logic regWr;
	cefm_byte_t regWdata;
	cefm_byte_t regRdata;
	logic irqReq;
	int mismatches;
	int samplesChecked;
	int cycles;
	logic [15:0] lfsrState;
	cefm_byte_t got;
	cefm_byte_t m;
	logic [24:0] r;
	int bitOf[25] = '{6, 5, 4, 3, 2, 1, 0, 7, 5, 4, 3, 2, 1, 0,
		7, 6, 5, 4, 0, 6, 5, 4, 2, 1, 0};
	logic [24:0] cornerEvt[4] = '{25'h1FFFFFF, 25'h0, 25'h200, 25'h7F};
	cefm_byte_t cornerMask[4] = '{8'hFF, 8'h00, 8'h00, 8'hFF};
	cefm_event_flags dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regRd(regRd), .regWr(regWr), .regWdata(regWdata),
		.regRdata(regRdata), .irqReq(irqReq),
		.taperEntryEvent(evt[0]), .chargeDoneEvent(evt[1]),
		.inputLimitEvent(evt[2]), .outputDpmEvent(evt[3]),
		.inputDpmEvent(evt[4]), .thermalRegEvent(evt[5]),
		.inputPowerGood(evt[6]), .inputOvervoltageEvent(evt[7]),
		.batteryOvercurrentEvent(evt[8]), .batteryUndervoltageEvent(evt[9]),
		.thermistorColdEntry(evt[10]), .thermistorCoolEntry(evt[11]),
		.thermistorWarmEntry(evt[12]), .thermistorHotEntry(evt[13]),
		.adcReadyEvent(evt[14]), .comparatorOneAlarm(evt[15]),
		.comparatorTwoAlarm(evt[16]), .comparatorThreeAlarm(evt[17]),
		.thermistorOpenEvent(evt[18]), .watchdogExpiryEvent(evt[19]),
		.chargeTimerExpiryEvent(evt[20]),
		.auxRegulatorOvercurrentEvent(evt[21]),
		.buttonWakeFirstExpiry(evt[22]), .buttonWakeSecondExpiry(evt[23]),
		.buttonResetWarningExpiry(evt[24]));
	cefm_host_model host (.clk(clk), .regAddr(regAddr), .regRd(regRd),
		.regWr(regWr), .regWdata(regWdata), .regRdata(regRdata));
	function automatic logic [15:0] lfsr(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	function automatic int regOf(int i);
		return (i < 7) ? 3 : (i < 14) ? 4 : (i < 19) ? 5 : 6;
	endfunction : regOf
	// Undervoltage bit idles at one and drops on its event
	function automatic cefm_byte_t expReg(logic [24:0] v, int k);
		cefm_byte_t e;
		e = (k == 4) ? 8'h10 : 8'h00;
		for (int i = 0; i < 25; i++)
			if (v[i] && regOf(i) == k) e = e ^ (8'h01 << bitOf[i]);
		return e;
	endfunction : expReg
	function automatic logic expIrq(logic [24:0] v, cefm_byte_t mk);
		logic q;
		q = |v[24:7];
		for (int i = 0; i < 7; i++) q = q | (v[i] & !mk[6 - i]);
		return q;
	endfunction : expIrq
	task automatic check(cefm_byte_t seen, cefm_byte_t want);
		samplesChecked++;
		if (seen !== want) begin
			mismatches++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samplesChecked, mismatches);
		if (mismatches == 0 && samplesChecked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			print_verdict();
		end
	end
	initial begin
		sys_rst = 1'b1;
		evt = '0;
		lfsrState = 16'h051E;
		repeat (20) @(posedge clk);
		#10 sys_rst = 1'b0;
		repeat (3) @(posedge clk);
		check({7'h00, irqReq}, 8'h00);
		for (int k = 2; k < 9; k++) begin
			host.rd(8'(k), got);
			check(got, expReg('0, k));
		end
		for (int n = 0; n < 40; n++) begin
			lfsrState = lfsr(lfsrState);
			m = lfsrState[7:0];
			r = {lfsrState[8:0], lfsr(lfsrState)};
			lfsrState = lfsr(lfsrState);
			if (n < 4) begin
				r = cornerEvt[n];
				m = cornerMask[n];
			end
			host.wr(8'h07, m);
			host.rd(8'h07, got);
			check(got, m & 8'h7F);
			@(posedge clk) #10 evt = r;
			repeat (6) @(posedge clk);
			#10 evt = '0;
			repeat (6) @(posedge clk);
			check({7'h00, irqReq}, {7'h00, expIrq(r, m)});
			for (int k = 3; k < 7; k++) begin
				host.rd(8'(k), got);
				check(got, expReg(r, k));
			end
			for (int k = 3; k < 7; k++) begin
				host.rd(8'(k), got);
				check(got, expReg('0, k));
			end
			check({7'h00, irqReq}, 8'h00);
		end
		print_verdict();
	end
endmodule : charger_event_flags_masks_tb_top
